//--- verilog/offset_store.sv
/*
  Command handler for stored offset tables and named setup slots.
  Takes decoded commands one at a time, streams list items in and answers out.
  Assumes table selection is done elsewhere and shown on i_table_active/index.
*/
// Operation
// - Free-space queries answer bytes available, then bytes in use.
// - Slot count query always answers ten.
// - Slot name listing returns names in ascending slot order.
// - Slot naming binds a name of up to 12 legal characters to slot 0-9.
// - Name query returns the slot number bound to that name.
// - Slot number out of range is rejected with error 222.
// - Bad name length or characters is rejected with error 224.
// - Naming with a name held by another slot gives error 257.
// - Ten tables of up to 512 points each are held.
// - Frequency write discards old frequency list before storing new entries.
// - Frequencies must ascend; otherwise error 220.
// - Frequency outside 1 kHz to 1000 GHz gives error 222.
// - Accepted frequencies are truncated to whole kilohertz.
// - Frequency list above 512 entries gives error 108.
// - List write with no active table stores nothing, error 221.
// - Frequency list query returns points in hertz.
// - Point count query returns count, zero if empty, NaN if no table.
// - Offset write discards old offset list before storing new entries.
// - Offset outside 1.0 to 150.0 percent gives error 222.
// - Offset list above 512 entries gives error 108.
// - Nth frequency pairs with nth offset.
// - Outside the table span the nearest end point offset applies.
`timescale 1ns/1ns
module offset_store
  import offset_store_pkg::*;
(
  input wire logic i_core_clk, // 10 MHz clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_cmd_valid, // Command offered
  input wire op_e i_cmd_op, // Command code
  input wire logic [SLOT_W-1:0] i_cmd_slot, // Slot number for naming
  input wire logic [NAME_W-1:0] i_cmd_name, // Name, first char in low byte
  input wire logic [LEN_W-1:0] i_cmd_name_len, // Name length in chars
  input wire logic [HZ_W-1:0] i_cmd_freq_hz, // Measured frequency for lookup
  output logic o_cmd_ready, // Command taken when high with valid
  input wire logic i_item_valid, // List item offered
  input wire logic [HZ_W-1:0] i_item_data, // Hz or tenths of a percent
  input wire logic i_item_last, // Last item of the list
  output logic o_item_ready, // List item taken when high with valid
  input wire logic i_table_active, // A table is selected
  input wire logic [TBL_W-1:0] i_table_index, // Selected table
  output logic o_resp_valid, // Answer beat
  output logic o_resp_last, // Last answer beat of a command
  output logic o_resp_nan, // Answer is not a number
  output logic [HZ_W-1:0] o_resp_val0, // First value
  output logic [HZ_W-1:0] o_resp_val1, // Second value
  output logic [NAME_W-1:0] o_resp_name, // Slot name in listings
  output logic o_err_valid, // Command rejected
  output logic [CODE_W-1:0] o_err_code // Error magnitude
);

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_LIST, ST_READ, ST_LOOKUP} state_e;

  // ==========================================================================
  // Name helpers
  function automatic logic char_ok(input logic [7:0] c);
    char_ok = (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a) ||
      (c >= 8'h30 && c <= 8'h39) || (c == 8'h5f);
  endfunction

  function automatic logic [NAME_W-1:0] name_mask(input logic [NAME_W-1:0] n,
                                                  input logic [LEN_W-1:0] len);
    logic [NAME_W-1:0] m;
    m = '0;
    for (int i = 0; i < NAME_CHARS; i++) begin
      if (LEN_W'(i) < len) begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    name_mask = m;
  endfunction

  function automatic logic name_ok(input logic [NAME_W-1:0] n, input logic [LEN_W-1:0] len);
    logic ok;
    ok = (len != '0) && (len <= NAME_LIMIT);
    for (int i = 0; i < NAME_CHARS; i++) begin
      if (LEN_W'(i) < len && !char_ok(n[i*8 +: 8])) begin
        ok = 1'b0;
      end
    end
    name_ok = ok;
  endfunction

  // ==========================================================================
  // State
  state_e state_r, state_nxt;
  op_e op_r, op_nxt;
  logic [TBL_W-1:0] tbl_r, tbl_nxt;
  logic [CNT_W-1:0] idx_r, idx_nxt;
  logic [CODE_W-1:0] err_r, err_nxt;
  logic [HZ_W-1:0] prev_r, prev_nxt;
  logic [KHZ_W-1:0] meas_r, meas_nxt;
  logic [CORR_W-1:0] sel_r, sel_nxt;
  logic resp_valid_r, resp_valid_nxt, resp_last_r, resp_last_nxt, nan_r, nan_nxt;
  logic [HZ_W-1:0] val0_r, val0_nxt, val1_r, val1_nxt;
  logic [NAME_W-1:0] rname_r, rname_nxt;
  logic err_valid_r, err_valid_nxt;
  logic [CODE_W-1:0] err_code_r, err_code_nxt;

  // Data storage has no reset: counts define which entries are meaningful
  logic [KHZ_W-1:0] freq_mem_r [NUM_TABLES][MAX_POINTS];
  logic [CORR_W-1:0] corr_mem_r [NUM_TABLES][MAX_POINTS];
  logic [CNT_W-1:0] freq_cnt_r [NUM_TABLES];
  logic [CNT_W-1:0] corr_cnt_r [NUM_TABLES];
  logic [NAME_W-1:0] slot_name_r [NUM_SLOTS];
  logic [LEN_W-1:0] slot_len_r [NUM_SLOTS];

  // ==========================================================================
  // Decode
  wire take = i_cmd_valid && (state_r == ST_IDLE);
  wire active = i_table_active && (i_table_index < TABLE_LIMIT);
  wire is_freq = (op_r == OP_FREQ_WRITE) || (op_r == OP_FREQ_READ);
  wire [NAME_W-1:0] cmd_name_m = name_mask(i_cmd_name, i_cmd_name_len);
  wire cmd_name_ok = name_ok(i_cmd_name, i_cmd_name_len);
  wire slot_bad = i_cmd_slot >= SLOT_LIMIT;
  logic [NUM_SLOTS-1:0] name_hit;
  logic [NUM_SLOTS-1:0] name_dup;

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_match
      assign name_hit[gs] = (slot_len_r[gs] == i_cmd_name_len) &&
        (slot_name_r[gs] == cmd_name_m);
      assign name_dup[gs] = name_hit[gs] && (i_cmd_slot != SLOT_W'(gs));
    end
  endgenerate

  logic [HZ_W-1:0] hit_slot;
  logic [HZ_W-1:0] table_used;
  logic [HZ_W-1:0] slot_used;
  always_comb begin
    hit_slot = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (name_hit[s]) begin
        hit_slot = HZ_W'(s);
      end
    end
  end

  // Byte usage is derived from counts, so it can never drift from contents
  always_comb begin
    table_used = '0;
    slot_used = '0;
    for (int t = 0; t < NUM_TABLES; t++) begin
      table_used = table_used + HZ_W'(freq_cnt_r[t]) * FREQ_BYTES + HZ_W'(corr_cnt_r[t]) * CORR_BYTES;
    end
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_len_r[s] != '0) begin
        slot_used = slot_used + SLOT_BYTES;
      end
    end
  end

  // List item checks
  wire [HZ_W-1:0] d = i_item_data;
  wire item_over = idx_r == POINTS_LIMIT;
  wire freq_bad = (d < FREQ_MIN_HZ) || (d > FREQ_MAX_HZ);
  wire corr_bad = (d > HZ_W'(CORR_MAX)) || (d < HZ_W'(CORR_MIN));
  wire order_bad = is_freq && (idx_r != '0) && (d <= prev_r);
  wire [CODE_W-1:0] item_err = item_over ? ERR_NOT_ALLOWED :
    ((is_freq ? freq_bad : corr_bad) ? ERR_RANGE : (order_bad ? ERR_ORDER : ERR_NONE));
  wire item_take = (state_r == ST_WRITE) && i_item_valid;
  wire item_final = item_take && i_item_last;
  wire [CODE_W-1:0] final_err = (err_r != ERR_NONE) ? err_r : item_err;
  wire mem_we = item_take && (err_r == ERR_NONE) && (item_err == ERR_NONE);
  wire [KHZ_W-1:0] item_khz = KHZ_W'(d / HZ_PER_KHZ);
  wire [CNT_W-1:0] cur_cnt = is_freq ? freq_cnt_r[tbl_r] : corr_cnt_r[tbl_r];
  wire [CNT_W-1:0] pair_cnt = (freq_cnt_r[tbl_r] < corr_cnt_r[tbl_r]) ?
    freq_cnt_r[tbl_r] : corr_cnt_r[tbl_r];
  wire [CNT_W-1:0] sel_cnt = (freq_cnt_r[i_table_index] < corr_cnt_r[i_table_index]) ?
    freq_cnt_r[i_table_index] : corr_cnt_r[i_table_index];
  wire [HZ_W-1:0] read_freq = HZ_W'({10'h000, freq_mem_r[tbl_r][idx_r[8:0]]} * HZ_PER_KHZ);

  // ==========================================================================
  // Control
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    tbl_nxt = tbl_r;
    idx_nxt = idx_r;
    err_nxt = err_r;
    prev_nxt = prev_r;
    meas_nxt = meas_r;
    sel_nxt = sel_r;
    resp_valid_nxt = 1'b0;
    resp_last_nxt = 1'b0;
    nan_nxt = 1'b0;
    val0_nxt = '0;
    val1_nxt = '0;
    rname_nxt = '0;
    err_valid_nxt = 1'b0;
    err_code_nxt = ERR_NONE;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          op_nxt = i_cmd_op;
          tbl_nxt = i_table_index;
          idx_nxt = '0;
          err_nxt = ERR_NONE;
          meas_nxt = KHZ_W'(i_cmd_freq_hz / HZ_PER_KHZ);
          sel_nxt = corr_mem_r[i_table_index][0];
          resp_valid_nxt = 1'b1;
          resp_last_nxt = 1'b1;
          unique case (i_cmd_op)
            OP_FREE_ALL: begin
              val0_nxt = TABLE_CAPACITY + SLOT_CAPACITY - table_used - slot_used;
              val1_nxt = table_used + slot_used;
            end
            OP_FREE_SLOT: begin
              val0_nxt = SLOT_CAPACITY - slot_used;
              val1_nxt = slot_used;
            end
            OP_FREE_TABLE: begin
              val0_nxt = TABLE_CAPACITY - table_used;
              val1_nxt = table_used;
            end
            OP_SLOT_COUNT: val0_nxt = SLOT_COUNT_ANSWER;
            OP_SLOT_LIST: begin
              resp_valid_nxt = 1'b0;
              state_nxt = ST_LIST;
            end
            OP_SLOT_NAME: begin
              // Range is checked before the name itself
              if (slot_bad || !cmd_name_ok || (|name_dup)) begin
                resp_valid_nxt = 1'b0;
                err_valid_nxt = 1'b1;
                err_code_nxt = slot_bad ? ERR_RANGE :
                  (!cmd_name_ok ? ERR_ILLEGAL : ERR_FILE_NAME);
              end
            end
            OP_SLOT_QUERY: begin
              if (cmd_name_ok && (|name_hit)) begin
                val0_nxt = hit_slot;
              end else begin
                resp_valid_nxt = 1'b0;
                err_valid_nxt = 1'b1;
                err_code_nxt = ERR_ILLEGAL;
              end
            end
            OP_FREQ_WRITE, OP_CORR_WRITE: begin
              resp_valid_nxt = 1'b0;
              err_nxt = active ? ERR_NONE : ERR_CONFLICT;
              state_nxt = ST_WRITE;
            end
            OP_FREQ_POINTS, OP_CORR_POINTS: begin
              nan_nxt = !active;
              val0_nxt = !active ? '0 : HZ_W'((i_cmd_op == OP_FREQ_POINTS) ?
                freq_cnt_r[i_table_index] : corr_cnt_r[i_table_index]);
            end
            OP_FREQ_READ, OP_CORR_READ, OP_LOOKUP: begin
              resp_valid_nxt = 1'b0;
              if (!active || ((i_cmd_op == OP_LOOKUP) && (sel_cnt == '0))) begin
                err_valid_nxt = 1'b1;
                err_code_nxt = ERR_CONFLICT;
              end else begin
                state_nxt = (i_cmd_op == OP_LOOKUP) ? ST_LOOKUP : ST_READ;
              end
            end
            default: begin
              resp_valid_nxt = 1'b0;
              err_valid_nxt = 1'b1;
              err_code_nxt = ERR_ILLEGAL;
            end
          endcase
        end
      end
      ST_WRITE: begin
        if (item_take) begin
          err_nxt = final_err; // First error seen wins
          prev_nxt = d;
          idx_nxt = item_over ? idx_r : idx_r + 10'h001;
          if (i_item_last) begin
            state_nxt = ST_IDLE;
            err_valid_nxt = final_err != ERR_NONE;
            err_code_nxt = final_err;
            resp_valid_nxt = final_err == ERR_NONE;
            resp_last_nxt = final_err == ERR_NONE;
          end
        end
      end
      ST_LIST: begin
        resp_valid_nxt = 1'b1;
        rname_nxt = slot_name_r[idx_r[3:0]];
        val0_nxt = HZ_W'(idx_r);
        resp_last_nxt = idx_r == CNT_W'(SLOT_LIMIT - 8'h01);
        idx_nxt = idx_r + 10'h001;
        if (resp_last_nxt) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_READ: begin
        // An empty list answers one beat with val1 zero
        resp_valid_nxt = 1'b1;
        val1_nxt = HZ_W'(cur_cnt);
        if (cur_cnt != '0) begin
          val0_nxt = is_freq ? read_freq : HZ_W'(corr_mem_r[tbl_r][idx_r[8:0]]);
        end
        resp_last_nxt = (cur_cnt == '0) || (idx_r == cur_cnt - 10'h001);
        idx_nxt = idx_r + 10'h001;
        if (resp_last_nxt) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_LOOKUP: begin
        // Step lookup over ascending points; the first point covers below span
        if (freq_mem_r[tbl_r][idx_r[8:0]] <= meas_r) begin
          sel_nxt = corr_mem_r[tbl_r][idx_r[8:0]];
        end
        idx_nxt = idx_r + 10'h001;
        if (idx_r == pair_cnt - 10'h001) begin
          state_nxt = ST_IDLE;
          resp_valid_nxt = 1'b1;
          resp_last_nxt = 1'b1;
          val0_nxt = HZ_W'(sel_nxt);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
      op_r <= OP_FREE_ALL;
      tbl_r <= '0;
      idx_r <= '0;
      err_r <= ERR_NONE;
      prev_r <= '0;
      meas_r <= '0;
      sel_r <= '0;
      resp_valid_r <= 1'b0;
      resp_last_r <= 1'b0;
      nan_r <= 1'b0;
      val0_r <= '0;
      val1_r <= '0;
      rname_r <= '0;
      err_valid_r <= 1'b0;
      err_code_r <= ERR_NONE;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      tbl_r <= tbl_nxt;
      idx_r <= idx_nxt;
      err_r <= err_nxt;
      prev_r <= prev_nxt;
      meas_r <= meas_nxt;
      sel_r <= sel_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_last_r <= resp_last_nxt;
      nan_r <= nan_nxt;
      val0_r <= val0_nxt;
      val1_r <= val1_nxt;
      rname_r <= rname_nxt;
      err_valid_r <= err_valid_nxt;
      err_code_r <= err_code_nxt;
    end
  end

  // ==========================================================================
  // Counts and slot names
  wire start_write = take && active &&
    ((i_cmd_op == OP_FREQ_WRITE) || (i_cmd_op == OP_CORR_WRITE));
  wire name_write = take && (i_cmd_op == OP_SLOT_NAME) && !slot_bad && cmd_name_ok &&
    !(|name_dup);
  wire [CNT_W-1:0] done_cnt = (final_err == ERR_NONE) ? idx_r + 10'h001 : '0;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int t = 0; t < NUM_TABLES; t++) begin
        freq_cnt_r[t] <= '0;
        corr_cnt_r[t] <= '0;
      end
      for (int s = 0; s < NUM_SLOTS; s++) begin
        slot_name_r[s] <= '0;
        slot_len_r[s] <= '0;
      end
    end else begin
      if (start_write && (i_cmd_op == OP_FREQ_WRITE)) begin
        freq_cnt_r[i_table_index] <= '0;
      end
      if (start_write && (i_cmd_op == OP_CORR_WRITE)) begin
        corr_cnt_r[i_table_index] <= '0;
      end
      // A rejected list leaves that list of the table empty, since the old list is gone
      if (item_final && is_freq) begin
        freq_cnt_r[tbl_r] <= done_cnt;
      end
      if (item_final && !is_freq) begin
        corr_cnt_r[tbl_r] <= done_cnt;
      end
      if (name_write) begin
        slot_name_r[i_cmd_slot[3:0]] <= cmd_name_m;
        slot_len_r[i_cmd_slot[3:0]] <= i_cmd_name_len;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (mem_we && is_freq) begin
      freq_mem_r[tbl_r][idx_r[8:0]] <= item_khz;
    end
    if (mem_we && !is_freq) begin
      corr_mem_r[tbl_r][idx_r[8:0]] <= CORR_W'(d);
    end
  end

  assign o_cmd_ready = state_r == ST_IDLE;
  assign o_item_ready = state_r == ST_WRITE;
  assign o_resp_valid = resp_valid_r;
  assign o_resp_last = resp_last_r;
  assign o_resp_nan = nan_r;
  assign o_resp_val0 = val0_r;
  assign o_resp_val1 = val1_r;
  assign o_resp_name = rname_r;
  assign o_err_valid = err_valid_r;
  assign o_err_code = err_code_r;

endmodule

//--- pkg/offset_store_pkg.sv
/*
  Shared constants for the offset table and setup-slot command handler:
  sizes, value ranges, error codes, byte accounting and command codes.
  Assumes the host side decodes text commands into the command codes below.
*/
package offset_store_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SLOTS = 10;
  localparam int NUM_TABLES = 10;
  localparam int MAX_POINTS = 512;
  localparam int NAME_CHARS = 12;
  localparam int SLOT_W = 8;
  localparam int TBL_W = 4;
  localparam int CNT_W = 10;
  localparam int HZ_W = 40;
  localparam int KHZ_W = 30;
  localparam int CORR_W = 11;
  localparam int NAME_W = 8 * NAME_CHARS;
  localparam int LEN_W = 5;
  localparam int CODE_W = 9;

  localparam logic [CNT_W-1:0] POINTS_LIMIT = 10'h200;
  localparam logic [SLOT_W-1:0] SLOT_LIMIT = 8'h0a;
  localparam logic [TBL_W-1:0] TABLE_LIMIT = 4'ha;
  localparam logic [LEN_W-1:0] NAME_LIMIT = 5'h0c;
  localparam logic [HZ_W-1:0] SLOT_COUNT_ANSWER = 40'h0a;

  // ==========================================================================
  // Value ranges; offsets are in tenths of a percent
  localparam logic [HZ_W-1:0] FREQ_MIN_HZ = 40'h3e8;
  localparam logic [HZ_W-1:0] FREQ_MAX_HZ = 40'he8d4a51000;
  localparam logic [HZ_W-1:0] HZ_PER_KHZ = 40'h3e8;
  localparam logic [CORR_W-1:0] CORR_MIN = 11'h00a;
  localparam logic [CORR_W-1:0] CORR_MAX = 11'h5dc;

  // ==========================================================================
  // Error codes, magnitude only (reported value is the negative)
  localparam logic [CODE_W-1:0] ERR_NONE = 9'h000;
  localparam logic [CODE_W-1:0] ERR_NOT_ALLOWED = 9'h06c;
  localparam logic [CODE_W-1:0] ERR_ORDER = 9'h0dc;
  localparam logic [CODE_W-1:0] ERR_CONFLICT = 9'h0dd;
  localparam logic [CODE_W-1:0] ERR_RANGE = 9'h0de;
  localparam logic [CODE_W-1:0] ERR_ILLEGAL = 9'h0e0;
  localparam logic [CODE_W-1:0] ERR_FILE_NAME = 9'h101;

  // ==========================================================================
  // Byte accounting
  localparam logic [HZ_W-1:0] FREQ_BYTES = 40'h4;
  localparam logic [HZ_W-1:0] CORR_BYTES = 40'h2;
  localparam logic [HZ_W-1:0] SLOT_BYTES = 40'h20;
  localparam logic [HZ_W-1:0] TABLE_CAPACITY = 40'h7800;
  localparam logic [HZ_W-1:0] SLOT_CAPACITY = 40'h140;

  // ==========================================================================
  // Command codes
  typedef enum logic [3:0] {
    OP_FREE_ALL,
    OP_FREE_SLOT,
    OP_FREE_TABLE,
    OP_SLOT_COUNT,
    OP_SLOT_LIST,
    OP_SLOT_NAME,
    OP_SLOT_QUERY,
    OP_FREQ_WRITE,
    OP_FREQ_READ,
    OP_FREQ_POINTS,
    OP_CORR_WRITE,
    OP_CORR_READ,
    OP_CORR_POINTS,
    OP_LOOKUP
  } op_e;

endpackage

//--- dv/offset_store_chk.sv
/*
  Concurrent checks on the offset table command handler ports.
  Assumes one clock domain and the package command codes.
*/
`timescale 1ns/1ns
module offset_store_chk
  import offset_store_pkg::*;
(
  input wire logic i_core_clk, // clock
  input wire logic i_reset_n, // reset, active low
  input wire logic i_cmd_valid, // command offered
  input wire op_e i_cmd_op, // command code
  input wire logic [SLOT_W-1:0] i_cmd_slot, // slot number
  input wire logic [LEN_W-1:0] i_cmd_name_len, // name length
  input wire logic o_cmd_ready, // command taken
  input wire logic i_item_valid, // item offered
  input wire logic i_item_last, // final item
  input wire logic o_item_ready, // item taken
  input wire logic i_table_active, // table selected
  input wire logic o_resp_valid, // answer beat
  input wire logic o_resp_last, // final beat
  input wire logic o_resp_nan, // not a number
  input wire logic [HZ_W-1:0] o_resp_val0, // first value
  input wire logic [HZ_W-1:0] o_resp_val1, // second value
  input wire logic o_err_valid, // rejected
  input wire logic [CODE_W-1:0] o_err_code // error magnitude
);
  // ==========================================================================
  // Checks
  wire take = i_cmd_valid && o_cmd_ready;
  wire naming = take && i_cmd_op == OP_SLOT_NAME;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence ten_beats;
    (o_resp_valid && !o_resp_last)[*8] ##1 (o_resp_valid && !o_resp_last)
      ##1 (o_resp_valid && o_resp_last);
  endsequence
  a_count_answer:
    assert property (take && i_cmd_op == OP_SLOT_COUNT |=> o_resp_valid && o_resp_last
      && o_resp_val0 == SLOT_COUNT_ANSWER) else $error("slot count answer wrong");
  a_listing_beats:
    assert property (take && i_cmd_op == OP_SLOT_LIST |=> !o_resp_valid ##1 ten_beats)
    else $error("slot listing beats wrong");
  a_slot_range:
    assert property (naming && i_cmd_slot >= SLOT_LIMIT |=> o_err_valid
      && o_err_code == ERR_RANGE) else $error("slot range not refused");
  a_name_length:
    assert property (naming && i_cmd_slot < SLOT_LIMIT && (i_cmd_name_len == 5'h00
      || i_cmd_name_len > NAME_LIMIT) |=> o_err_valid && o_err_code == ERR_ILLEGAL)
    else $error("bad name length not refused");
  a_points_nan:
    assert property (take && i_cmd_op == OP_FREQ_POINTS && !i_table_active
      |=> o_resp_valid && o_resp_nan) else $error("points without table not nan");
  a_slot_space:
    assert property (take && i_cmd_op == OP_FREE_SLOT |=> o_resp_valid
      && o_resp_val0 + o_resp_val1 == SLOT_CAPACITY) else $error("slot space sum wrong");
  a_table_space:
    assert property (take && i_cmd_op == OP_FREE_TABLE |=> o_resp_valid
      && o_resp_val0 + o_resp_val1 == TABLE_CAPACITY) else $error("table space sum wrong");
  a_list_open:
    assert property (take && i_cmd_op == OP_FREQ_WRITE |=> !o_cmd_ready && o_item_ready)
    else $error("list write not opened");
  a_list_close:
    assert property (o_item_ready && i_item_valid && i_item_last
      |=> (o_resp_valid && o_resp_last) != o_err_valid) else $error("list not closed");
endmodule
bind offset_store offset_store_chk chk (.*);

//--- dv/host_list_src.sv
/*
  Host model that streams one list of items into the handler.
  Assumes the bench fills vals and raises i_go for one cycle.
*/
`timescale 1ns/1ns
module host_list_src
  import offset_store_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_go, // start a list
  input wire logic [CNT_W-1:0] i_count, // items in list
  input wire logic i_slow, // idle cycle after each item
  input wire logic i_ready, // handler takes item
  output logic o_valid = 1'b0, // item offered
  output logic [HZ_W-1:0] o_data = '0, // item value
  output logic o_last = 1'b0 // final item
);
  // ==========================================================================
  // Stream
  logic [HZ_W-1:0] vals [0:MAX_POINTS];
  int idx = 0;
  bit busy = 0, took, go_s;
  always @(posedge i_clk) begin
    took = o_valid && i_ready;
    go_s = i_go;
    #10;
    if (go_s) begin
      idx = 0;
      busy = 1;
    end else if (took) begin
      busy = !o_last;
      idx = idx + 1;
    end
    if (busy && !(took && i_slow)) begin
      o_valid = 1'b1;
      o_data = vals[idx];
      o_last = idx == int'(i_count) - 1;
    end else begin
      o_valid = 1'b0;
      // Released bus never keeps its old value
      o_data = ~o_data;
      o_last = 1'b0;
    end
  end
endmodule

//--- dv/testbench.sv
/*
  Self-checking bench for the offset table command handler.
  Assumes the host list model and the checker bound to the handler.
*/
`timescale 1ns/1ns
module testbench
  import offset_store_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam logic [NAME_W-1:0] NM = "1PUTES";
  logic i_core_clk = 0, i_reset_n = 0, i_cmd_valid = 0, i_table_active = 0;
  op_e i_cmd_op = OP_FREE_ALL;
  logic [SLOT_W-1:0] i_cmd_slot = '0;
  logic [NAME_W-1:0] i_cmd_name = '0, o_resp_name, v0, v1, nm, ec;
  logic [LEN_W-1:0] i_cmd_name_len = '0;
  logic [HZ_W-1:0] i_cmd_freq_hz = '0, i_item_data, o_resp_val0, o_resp_val1;
  logic [TBL_W-1:0] i_table_index = '0;
  logic o_cmd_ready, o_item_ready, i_item_valid, i_item_last, o_resp_valid;
  logic o_resp_last, o_resp_nan, o_err_valid, bl, bn, go = 0, slow = 0;
  logic [CODE_W-1:0] o_err_code;
  logic [CNT_W-1:0] cnt = '0;
  int fails = 0, comparisons = 0;
  offset_store uut (.*);
  host_list_src src (.i_clk(i_core_clk), .i_go(go), .i_count(cnt), .i_slow(slow),
    .i_ready(o_item_ready), .o_valid(i_item_valid), .o_data(i_item_data),
    .o_last(i_item_last));
  initial forever #50 i_core_clk = ~i_core_clk;

  // ==========================================================================
  // Shared tasks
  task chk(string what, logic [NAME_W-1:0] seen, logic [NAME_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task get;
    int n;
    n = 0;
    do begin
      @(posedge i_core_clk);
      #10;
      i_cmd_valid = 0;
      n++;
    end while (o_resp_valid !== 1'b1 && o_err_valid !== 1'b1 && n < 2000);
    chk("answer", NAME_W'(n < 2000), 1);
    v0 = NAME_W'(o_resp_val0);
    v1 = NAME_W'(o_resp_val1);
    nm = o_resp_name;
    ec = NAME_W'(o_err_code);
    bl = o_resp_last;
    bn = o_resp_nan;
  endtask
  task run(op_e op, logic [SLOT_W-1:0] s = '0, logic [NAME_W-1:0] nv = '0,
           logic [LEN_W-1:0] l = '0, logic [HZ_W-1:0] f = '0);
    @(posedge i_core_clk);
    #10;
    go = 0;
    i_cmd_valid = 1;
    i_cmd_op = op;
    i_cmd_slot = s;
    i_cmd_name = nv;
    i_cmd_name_len = l;
    i_cmd_freq_hz = f;
    while (o_cmd_ready !== 1'b1) begin
      @(posedge i_core_clk);
      #10;
    end
    get;
  endtask
  task ck_err(logic [CODE_W-1:0] c);
    chk("err_code", ec, NAME_W'(c));
  endtask
  task wl(op_e op, int n, logic sl);
    cnt = CNT_W'(n);
    slow = sl;
    go = 1;
    run(op);
  endtask
  task pair(logic [HZ_W-1:0] a, logic [HZ_W-1:0] b, op_e op);
    src.vals[0] = a;
    src.vals[1] = b;
    wl(op, 2, 0);
  endtask
  task ramp(op_e op, int n, logic [HZ_W-1:0] base, logic [HZ_W-1:0] step);
    for (int k = 0; k < n; k++) src.vals[k] = base + step * HZ_W'(k);
    wl(op, n, 1);
  endtask

  // ==========================================================================
  // Scenarios
  task t_names;
    run(OP_SLOT_COUNT);
    chk("slot_count", v0, 10);
    run(OP_FREE_ALL);
    chk("free_avail", v0, NAME_W'(TABLE_CAPACITY + SLOT_CAPACITY));
    chk("free_used", v1, 0);
    run(OP_SLOT_NAME, 4, NM, 6);
    ck_err(ERR_NONE);
    run(OP_SLOT_QUERY, 0, NM, 6);
    chk("slot_of_name", v0, 4);
    run(OP_SLOT_NAME, 8'h0a, "A", 1);
    ck_err(ERR_RANGE);
    run(OP_SLOT_NAME, 2, "-A", 2);
    ck_err(ERR_ILLEGAL);
    run(OP_SLOT_NAME, 2, "ABCDEFGHIJKL", 5'h0d);
    ck_err(ERR_ILLEGAL);
    run(OP_SLOT_NAME, 3, NM, 6);
    ck_err(ERR_FILE_NAME);
    run(OP_SLOT_NAME, 4, NM, 6);
    ck_err(ERR_NONE);
    run(OP_SLOT_LIST);
    for (int k = 0; k < NUM_SLOTS; k++) begin
      if (k > 0) get;
      chk("list_slot", v0, k);
      chk("list_name", nm, k == 4 ? NM : '0);
      chk("list_last", bl, k == NUM_SLOTS - 1);
    end
  endtask
  task t_freq;
    pair(40'h30f34, 40'h92ba7, OP_FREQ_WRITE);
    ck_err(ERR_CONFLICT);
    run(OP_FREQ_POINTS);
    chk("nan", bn, 1);
    i_table_index = 4'h2;
    i_table_active = 1;
    pair(40'h30f34, 40'h92ba7, OP_FREQ_WRITE);
    ck_err(ERR_NONE);
    run(OP_FREQ_READ);
    chk("freq0", v0, 40'h30d40);
    chk("freq_count", v1, 2);
    get;
    chk("freq1", v0, 40'h927c0);
    pair(40'h927c0, 40'h30d40, OP_FREQ_WRITE);
    ck_err(ERR_ORDER);
    run(OP_FREQ_POINTS);
    chk("points", v0, 0);
    pair(40'h3e7, 40'h7d0, OP_FREQ_WRITE);
    ck_err(ERR_RANGE);
    pair(FREQ_MAX_HZ, FREQ_MAX_HZ + 40'h1, OP_FREQ_WRITE);
    ck_err(ERR_RANGE);
    ramp(OP_FREQ_WRITE, 513, 40'h3e8, 40'h3e8);
    ck_err(ERR_NOT_ALLOWED);
    ramp(OP_FREQ_WRITE, 512, 40'h3e8, 40'h3e8);
    ck_err(ERR_NONE);
    run(OP_FREQ_POINTS);
    chk("points", v0, 512);
    pair(40'h30f34, 40'h92ba7, OP_FREQ_WRITE);
    ck_err(ERR_NONE);
  endtask
  task t_corr;
    logic [HZ_W-1:0] fq [4] = '{40'h186a0, 40'h493e0, 40'h927c0, 40'h12a05f200};
    logic [HZ_W-1:0] ex [4] = '{40'h3e3, 40'h3e3, 40'h3ce, 40'h3ce};
    pair(40'h3e3, 40'h3ce, OP_CORR_WRITE);
    ck_err(ERR_NONE);
    run(OP_CORR_READ);
    get;
    chk("corr1", v0, 40'h3ce);
    pair(40'h9, 40'h14, OP_CORR_WRITE);
    ck_err(ERR_RANGE);
    pair(40'h5dc, 40'h5dd, OP_CORR_WRITE);
    ck_err(ERR_RANGE);
    ramp(OP_CORR_WRITE, 513, 40'ha, 40'h1);
    ck_err(ERR_NOT_ALLOWED);
    run(OP_CORR_POINTS);
    chk("corr_points", v0, 0);
    pair(40'h3e3, 40'h3ce, OP_CORR_WRITE);
    for (int k = 0; k < 4; k++) begin
      run(OP_LOOKUP, 0, 0, 0, fq[k]);
      chk("lookup", v0, ex[k]);
    end
    run(OP_FREE_TABLE);
    chk("table_used", v1, 40'hc);
    run(OP_FREE_SLOT);
    chk("slot_used", v1, SLOT_BYTES);
  endtask

  initial begin
    repeat (3) @(posedge i_core_clk);
    #10;
    i_reset_n = 1;
    t_names;
    t_freq;
    t_corr;
    tally_and_finish;
  end
  // Whole run needs about 3300 cycles
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    tally_and_finish;
  end
endmodule
